/* src/gat_pkg.sv */
// Constants for the gain amplifier trigger sequencer: register map, fields, timing counts.
// Assumes a 40 MHz core clock and an amplifier clock derived from it by a divider.
//
// Functional notes
// - Amplifier adds 12 clock periods plus 18 per gain-stage count before ADC trigger.
// - Pre-trigger before each conversion selects control set A or B.
// - Pre-trigger leads its hardware trigger by exactly one peripheral clock.
// - Sets A and B run one after the other on two successive triggers.
// - Both pre-trigger lines reach both ADC instances for simultaneous conversions.
// - Disabled amplifier forwards delay-block trigger and pre-trigger unchanged.
// - Software-triggered amplifier leaves delay-block pre-trigger free for the other ADC; the sequencer forwards it only while in GAT_S_READY.
// - Enabled hardware-triggered amplifier absorbs inputs and issues new delayed triggers.
// - Power-down keeps analog off and passes triggers straight to outputs.
// - After enable, 16 clock periods sample ground; no conversions meanwhile.
// - End of startup sets the startup-complete flag.
// - Calibration mode 10 samples differential ground on both inputs.
// - Calibration mode 00 samples the external input pins.
// - Long-sample 12-bit conversion takes 43 ADC clocks plus 5 peripheral clocks.
// - Gain-stage count n gives n+1 gain-stage clock assertions per conversion.
// - Stage clocks high at least 8, low at least 10, never both high.
// - ADC trigger issued at start of final gain-stage high phase.
// - Amplifier clock stopped idle, started on trigger, stopped after done.
package gat_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] GAT_ADDR_CTRL = 8'h00;
	localparam logic [7:0] GAT_ADDR_SWTRIG = 8'h04;
	localparam logic [7:0] GAT_ADDR_STATUS = 8'h08;

	// ==========================================================
	// Control register fields
	localparam int GAT_CTRL_EN_BIT = 0;
	localparam int GAT_CTRL_HWTRIG_BIT = 1;
	localparam int GAT_CTRL_CAL_LSB = 2;
	localparam int GAT_CTRL_GS_LSB = 4;
	localparam int GAT_CTRL_SWSET_BIT = 8;
	localparam logic [31:0] GAT_CTRL_RESET = 32'h0000_0032;

	// Status register fields
	localparam int GAT_STAT_STARTUP_COMPLETE_FLAG_BIT = 0;
	localparam int GAT_STAT_BUSY_BIT = 1;
	localparam int GAT_STAT_CLKRUN_BIT = 2;

	// Calibration mode encodings
	localparam logic [1:0] GAT_CAL_MISSION = 2'h0;
	localparam logic [1:0] GAT_CAL_GROUND = 2'h2;

	// ==========================================================
	// Timing counts in amplifier clock periods unless noted
	localparam logic [5:0] GAT_HI_TICKS = 6'h08;
	localparam logic [5:0] GAT_PERIOD_TICKS = 6'h12;
	localparam logic [5:0] GAT_BASE_TICKS = 6'h0C;
	localparam logic [5:0] GAT_FINAL_TICKS = 6'h24;
	localparam logic [5:0] GAT_CONV_ADC_TICKS = 6'h2B;
	localparam logic [5:0] GAT_CONV_PCLK = 6'h05;
	localparam logic [3:0] GAT_STARTUP_PERIODS = 4'hF;

	// ==========================================================
	// Sequencer states
	typedef enum logic [2:0] {
		GAT_S_OFF = 3'b000,
		GAT_S_START = 3'b001,
		GAT_S_READY = 3'b010,
		GAT_S_PRE = 3'b011,
		GAT_S_GS = 3'b100,
		GAT_S_FINAL = 3'b101,
		GAT_S_CONV = 3'b110,
		GAT_S_TAIL = 3'b111
	} gat_state_e;

endpackage

/* src/gat_sequencer.sv */
// Gain amplifier trigger sequencer: APB registers, startup, trigger routing, clock phases.
// Assumes APB master on core_clk, delay-block trigger inputs synchronous to core_clk.
module gat_sequencer #(
	parameter int AMP_CLK_DIV = 5,
	parameter int GS_W = 3
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Delay block triggers in
	input wire logic dly_trig,
	input wire logic dly_pretrig_a,
	input wire logic dly_pretrig_b,
	// Triggers toward both ADCs
	output logic adc_trig,
	output logic adc_pretrig_a,
	output logic adc_pretrig_b,
	output logic free_pretrig_a,
	output logic free_pretrig_b,
	// Analog control
	output logic analog_on,
	output logic sh_clk,
	output logic gs_clk,
	output logic amp_clk_run,
	output logic [1:0] input_sel,
	output logic amp_done
);

	initial begin
		if (AMP_CLK_DIV < 1 || GS_W < 1 || GS_W > 4)
			$error("gat_sequencer: unsupported parameter values");
	end

	// ==========================================================
	// Register file
	logic [31:0] ctrl_reg;
	logic [31:0] ctrl_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic pslverr_next;
	logic sw_trig_reg;
	logic sw_trig_next;
	logic startup_complete_flag_reg;
	logic startup_complete_flag_next;

	logic en;
	logic hw_mode;
	logic [1:0] cal_sel;
	logic [GS_W-1:0] gs_n;
	logic wr_en;
	logic rd_setup;

	assign en = ctrl_reg[gat_pkg::GAT_CTRL_EN_BIT];
	assign hw_mode = ctrl_reg[gat_pkg::GAT_CTRL_HWTRIG_BIT];
	assign cal_sel = ctrl_reg[gat_pkg::GAT_CTRL_CAL_LSB +: 2];
	assign gs_n = ctrl_reg[gat_pkg::GAT_CTRL_GS_LSB +: GS_W];
	assign wr_en = psel && penable && pwrite && pready_reg;
	assign rd_setup = psel && !penable;

	function automatic logic addr_mapped(input logic [7:0] a);
		logic hit;
		hit = 1'b0;
		if (a == gat_pkg::GAT_ADDR_CTRL)
			hit = 1'b1;
		else if (a == gat_pkg::GAT_ADDR_SWTRIG)
			hit = 1'b1;
		else if (a == gat_pkg::GAT_ADDR_STATUS)
			hit = 1'b1;
		return hit;
	endfunction

	// ==========================================================
	// Sequencer state
	gat_pkg::gat_state_e state_reg;
	gat_pkg::gat_state_e state_next;
	logic [5:0] cnt_reg;
	logic [5:0] cnt_next;
	logic [3:0] per_reg;
	logic [3:0] per_next;
	logic [GS_W-1:0] k_reg;
	logic [GS_W-1:0] k_next;
	logic set_b_reg;
	logic set_b_next;
	logic trig_pend_reg;
	logic trig_pend_next;
	logic tick;
	logic div_run_reg;
	logic div_run_next;

	logic adc_trig_reg, adc_trig_next;
	logic pre_a_reg, pre_a_next;
	logic pre_b_reg, pre_b_next;
	logic free_a_reg, free_a_next;
	logic free_b_reg, free_b_next;
	logic analog_reg, analog_next;
	logic sh_reg, sh_next;
	logic gs_reg, gs_next;
	logic clk_run_reg, clk_run_next;
	logic [1:0] in_sel_reg, in_sel_next;
	logic done_reg, done_next;

	gat_tick_div #(
		.DIV(AMP_CLK_DIV)
	) u_tick (
		.core_clk(core_clk),
		.rstn(rstn),
		.run(div_run_reg),
		.tick(tick)
	);

	// ==========================================================
	// Register next values
	always_comb begin
		ctrl_next = ctrl_reg;
		sw_trig_next = 1'b0;
		pready_next = rd_setup;
		pslverr_next = rd_setup && !addr_mapped(paddr);
		prdata_next = prdata_reg;
		if (rd_setup) begin
			prdata_next = '0;
			if (paddr == gat_pkg::GAT_ADDR_CTRL) begin
				prdata_next = ctrl_reg;
			end else if (paddr == gat_pkg::GAT_ADDR_STATUS) begin
				prdata_next[gat_pkg::GAT_STAT_STARTUP_COMPLETE_FLAG_BIT] = startup_complete_flag_reg;
				prdata_next[gat_pkg::GAT_STAT_BUSY_BIT] = (state_reg != gat_pkg::GAT_S_READY);
				prdata_next[gat_pkg::GAT_STAT_CLKRUN_BIT] = clk_run_reg;
			end
		end
		if (wr_en) begin
			if (paddr == gat_pkg::GAT_ADDR_CTRL) begin
				ctrl_next = pwdata & 32'h0000_01FF;
			end else if (paddr == gat_pkg::GAT_ADDR_SWTRIG) begin
				sw_trig_next = pwdata[0];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			ctrl_reg <= gat_pkg::GAT_CTRL_RESET;
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			sw_trig_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			sw_trig_reg <= sw_trig_next;
		end
	end

	// ==========================================================
	// Sequencer next values
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		per_next = per_reg;
		k_next = k_reg;
		set_b_next = set_b_reg;
		startup_complete_flag_next = startup_complete_flag_reg;
		trig_pend_next = 1'b0;
		done_next = 1'b0;
		pre_a_next = 1'b0;
		pre_b_next = 1'b0;
		adc_trig_next = trig_pend_reg;
		free_a_next = 1'b0;
		free_b_next = 1'b0;
		case (state_reg)
			gat_pkg::GAT_S_OFF: begin
				// Power-down pass-through
				adc_trig_next = dly_trig;
				pre_a_next = dly_pretrig_a;
				pre_b_next = dly_pretrig_b;
				if (en) begin
					state_next = gat_pkg::GAT_S_START;
					cnt_next = '0;
					per_next = '0;
				end
			end
			gat_pkg::GAT_S_START: begin
				if (tick) begin
					cnt_next = cnt_reg + 6'h01;
					if (cnt_reg == gat_pkg::GAT_PERIOD_TICKS - 6'h01) begin
						cnt_next = '0;
						per_next = per_reg + 4'h1;
						if (per_reg == gat_pkg::GAT_STARTUP_PERIODS) begin
							state_next = gat_pkg::GAT_S_READY;
							startup_complete_flag_next = 1'b1;
						end
					end
				end
			end
			gat_pkg::GAT_S_READY: begin
				cnt_next = '0;
				k_next = '0;
				if (hw_mode) begin
					// Consume delay-block inputs, remember the chosen set
					if (dly_pretrig_a)
						set_b_next = 1'b0;
					else if (dly_pretrig_b)
						set_b_next = 1'b1;
					if (dly_trig)
						state_next = gat_pkg::GAT_S_PRE;
				end else begin
					free_a_next = dly_pretrig_a;
					free_b_next = dly_pretrig_b;
					set_b_next = ctrl_reg[gat_pkg::GAT_CTRL_SWSET_BIT];
					if (sw_trig_reg)
						state_next = gat_pkg::GAT_S_PRE;
				end
			end
			gat_pkg::GAT_S_PRE: begin
				if (tick) begin
					cnt_next = cnt_reg + 6'h01;
					if (cnt_reg == gat_pkg::GAT_BASE_TICKS - 6'h01) begin
						cnt_next = '0;
						if (gs_n == '0) begin
							state_next = gat_pkg::GAT_S_FINAL;
							pre_a_next = !set_b_reg;
							pre_b_next = set_b_reg;
							trig_pend_next = 1'b1;
						end else begin
							state_next = gat_pkg::GAT_S_GS;
						end
					end
				end
			end
			gat_pkg::GAT_S_GS: begin
				if (tick) begin
					cnt_next = cnt_reg + 6'h01;
					if (cnt_reg == gat_pkg::GAT_PERIOD_TICKS - 6'h01) begin
						cnt_next = '0;
						k_next = k_reg + GS_W'(1);
						if (k_reg + GS_W'(1) == gs_n) begin
							state_next = gat_pkg::GAT_S_FINAL;
							pre_a_next = !set_b_reg;
							pre_b_next = set_b_reg;
							trig_pend_next = 1'b1;
						end
					end
				end
			end
			gat_pkg::GAT_S_FINAL: begin
				if (tick) begin
					cnt_next = cnt_reg + 6'h01;
					if (cnt_reg == gat_pkg::GAT_FINAL_TICKS - 6'h01) begin
						cnt_next = '0;
						state_next = gat_pkg::GAT_S_CONV;
						done_next = 1'b1;
					end
				end
			end
			gat_pkg::GAT_S_CONV: begin
				if (tick) begin
					cnt_next = cnt_reg + 6'h01;
					// ADC part of the long-sample conversion, then peripheral clocks
					if (cnt_reg == gat_pkg::GAT_CONV_ADC_TICKS - 6'h01) begin
						cnt_next = '0;
						state_next = gat_pkg::GAT_S_TAIL;
					end
				end
			end
			gat_pkg::GAT_S_TAIL: begin
				cnt_next = cnt_reg + 6'h01;
				if (cnt_reg == gat_pkg::GAT_CONV_PCLK - 6'h01) begin
					cnt_next = '0;
					state_next = gat_pkg::GAT_S_READY;
				end
			end
			default: begin
				state_next = gat_pkg::GAT_S_OFF;
			end
		endcase
		if (!en) begin
			state_next = gat_pkg::GAT_S_OFF;
			startup_complete_flag_next = 1'b0;
			trig_pend_next = 1'b0;
		end
	end

	// ==========================================================
	// Registered analog controls derived from the next state
	always_comb begin
		div_run_next = (state_next != gat_pkg::GAT_S_OFF) &&
			(state_next != gat_pkg::GAT_S_READY) && (state_next != gat_pkg::GAT_S_TAIL);
		clk_run_next = (state_next == gat_pkg::GAT_S_START) || (state_next == gat_pkg::GAT_S_PRE) ||
			(state_next == gat_pkg::GAT_S_GS) || (state_next == gat_pkg::GAT_S_FINAL);
		analog_next = (state_next != gat_pkg::GAT_S_OFF);
		sh_next = 1'b0;
		gs_next = 1'b0;
		// Sample-hold high ticks 0..7 of the lead-in; gaps keep both clocks apart
		case (state_next)
			gat_pkg::GAT_S_START: begin
				sh_next = !per_next[0] && (cnt_next < gat_pkg::GAT_HI_TICKS);
				gs_next = per_next[0] && (cnt_next < gat_pkg::GAT_HI_TICKS);
			end
			gat_pkg::GAT_S_PRE: sh_next = (cnt_next < gat_pkg::GAT_HI_TICKS);
			gat_pkg::GAT_S_GS: gs_next = (cnt_next < gat_pkg::GAT_HI_TICKS);
			gat_pkg::GAT_S_FINAL: gs_next = 1'b1;
			default: begin
				sh_next = 1'b0;
			end
		endcase
		if (state_next == gat_pkg::GAT_S_START)
			in_sel_next = gat_pkg::GAT_CAL_GROUND;
		else
			in_sel_next = cal_sel;
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			state_reg <= gat_pkg::GAT_S_OFF;
			cnt_reg <= 6'h00;
			per_reg <= 4'h0;
			k_reg <= '0;
			set_b_reg <= 1'b0;
			startup_complete_flag_reg <= 1'b0;
			trig_pend_reg <= 1'b0;
			div_run_reg <= 1'b0;
			adc_trig_reg <= 1'b0;
			pre_a_reg <= 1'b0;
			pre_b_reg <= 1'b0;
			free_a_reg <= 1'b0;
			free_b_reg <= 1'b0;
			analog_reg <= 1'b0;
			sh_reg <= 1'b0;
			gs_reg <= 1'b0;
			clk_run_reg <= 1'b0;
			in_sel_reg <= 2'h0;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			per_reg <= per_next;
			k_reg <= k_next;
			set_b_reg <= set_b_next;
			startup_complete_flag_reg <= startup_complete_flag_next;
			trig_pend_reg <= trig_pend_next;
			div_run_reg <= div_run_next;
			adc_trig_reg <= adc_trig_next;
			pre_a_reg <= pre_a_next;
			pre_b_reg <= pre_b_next;
			free_a_reg <= free_a_next;
			free_b_reg <= free_b_next;
			analog_reg <= analog_next;
			sh_reg <= sh_next;
			gs_reg <= gs_next;
			clk_run_reg <= clk_run_next;
			in_sel_reg <= in_sel_next;
			done_reg <= done_next;
		end
	end

	// ==========================================================
	// Outputs; pre-trigger lines fan out to both ADC instances
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign adc_trig = adc_trig_reg;
	assign adc_pretrig_a = pre_a_reg;
	assign adc_pretrig_b = pre_b_reg;
	assign free_pretrig_a = free_a_reg;
	assign free_pretrig_b = free_b_reg;
	assign analog_on = analog_reg;
	assign sh_clk = sh_reg;
	assign gs_clk = gs_reg;
	assign amp_clk_run = clk_run_reg;
	assign input_sel = in_sel_reg;
	assign amp_done = done_reg;

endmodule

/* src/gat_tick_div.sv */
// Amplifier clock tick generator: one-cycle tick every DIV core clocks while running.
// Assumes run is a registered level; counting restarts whenever run is low.
module gat_tick_div #(
	parameter int DIV = 5
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Control
	input wire logic run,
	// Tick out
	output logic tick
);

	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;

	initial begin
		if (DIV < 1)
			$error("gat_tick_div: DIV must be at least 1");
	end

	always_comb begin
		cnt_next = '0;
		if (run) begin
			if (cnt_reg != LAST) begin
				cnt_next = cnt_reg + CW'(1);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// Decoded from the counter so the first tick lands DIV clocks after run rises
	assign tick = run && (cnt_reg == LAST);

endmodule

/* tb/gain_amp_trigger_sequencer_tb.sv */
// Testbench for the sequencer: APB tasks, delay-block partner, event counters.
// Assumes AMP_CLK_DIV of 1, so one amplifier tick is one core cycle.
module gain_amp_trigger_sequencer_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk, rstn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic dly_trig, dly_pretrig_a, dly_pretrig_b, adc_trig, adc_pretrig_a, adc_pretrig_b;
	logic free_pretrig_a, free_pretrig_b, analog_on, sh_clk, gs_clk, amp_clk_run, amp_done;
	logic [1:0] input_sel;
	logic fire, sel_b, sh_q, gs_q;
	logic [3:0] gap;
	int mismatches, checks, cyc, n_trig, n_pa, n_pb, n_fa, n_fb, n_gs, n_done, t_sh, t_pre, t_done, t0;

	gat_sequencer #(.AMP_CLK_DIV(1), .GS_W(3)) u_dut (.core_clk(core_clk), .rstn(rstn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .dly_trig(dly_trig),
		.dly_pretrig_a(dly_pretrig_a), .dly_pretrig_b(dly_pretrig_b), .adc_trig(adc_trig),
		.adc_pretrig_a(adc_pretrig_a), .adc_pretrig_b(adc_pretrig_b),
		.free_pretrig_a(free_pretrig_a), .free_pretrig_b(free_pretrig_b),
		.analog_on(analog_on), .sh_clk(sh_clk), .gs_clk(gs_clk), .amp_clk_run(amp_clk_run),
		.input_sel(input_sel), .amp_done(amp_done));
	gat_dly_model u_dly (.core_clk(core_clk), .fire(fire), .sel_b(sel_b), .gap(gap),
		.dly_trig(dly_trig), .dly_pretrig_a(dly_pretrig_a), .dly_pretrig_b(dly_pretrig_b));

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// ==========================================================
	// Event counters and timeout
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		sh_q <= sh_clk;
		gs_q <= gs_clk;
		if (adc_trig === 1'b1) n_trig <= n_trig + 1;
		if (adc_pretrig_a === 1'b1) n_pa <= n_pa + 1;
		if (adc_pretrig_b === 1'b1) n_pb <= n_pb + 1;
		if (free_pretrig_a === 1'b1) n_fa <= n_fa + 1;
		if (free_pretrig_b === 1'b1) n_fb <= n_fb + 1;
		if (gs_clk === 1'b1 && gs_q === 1'b0) n_gs <= n_gs + 1;
		if (sh_clk === 1'b1 && sh_q === 1'b0) t_sh <= cyc;
		if (adc_pretrig_a === 1'b1 || adc_pretrig_b === 1'b1) t_pre <= cyc;
		if (amp_done === 1'b1) n_done <= n_done + 1;
		if (amp_done === 1'b1) t_done <= cyc;
		if (cyc == 20000) begin
			mismatches = mismatches + 1;
			wrap_up();
		end
	end

	// ==========================================================
	// Tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic poll(input int b, input logic v);
		do xfer(1'b0, gat_pkg::GAT_ADDR_STATUS, 32'h0); while (q[b] !== v);
	endtask

	task automatic fire_dly(input logic s, input logic [3:0] g);
		fire <= 1'b1;
		sel_b <= s;
		gap <= g;
		@(posedge core_clk);
		fire <= 1'b0;
		repeat (g + 6) @(posedge core_clk);
	endtask

	task automatic clr();
		n_trig = 0;
		n_pa = 0;
		n_pb = 0;
		n_fa = 0;
		n_fb = 0;
		n_gs = 0;
		n_done = 0;
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		fire = 1'b0;
		sel_b = 1'b0;
		gap = 4'h0;
		repeat (5) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		chk({adc_trig, adc_pretrig_a, adc_pretrig_b, free_pretrig_a, analog_on, amp_done}, 32'h0);
		xfer(1'b0, gat_pkg::GAT_ADDR_CTRL, 32'h0);
		chk(q, gat_pkg::GAT_CTRL_RESET);
		xfer(1'b0, 8'h0C, 32'h0);
		chk({q[31:1], err}, 32'h1);
		// Disabled: triggers pass straight through
		clr();
		fire_dly(1'b0, 4'h0);
		fire_dly(1'b1, 4'h3);
		chk(n_trig, 2);
		chk({n_pa[3:0], n_pb[3:0], n_fa[3:0]}, 32'h110);
		// Startup with ground sampling, trigger during it is absorbed
		xfer(1'b1, gat_pkg::GAT_ADDR_CTRL, 32'h0000_000B);
		t0 = cyc;
		xfer(1'b0, gat_pkg::GAT_ADDR_STATUS, 32'h0);
		chk(q[0], 1'b0);
		fire_dly(1'b0, 4'h0);
		poll(0, 1'b1);
		chk(32'(cyc - t0 >= 284 && cyc - t0 <= 296), 32'h1);
		chk(n_trig, 2);
		chk(input_sel, 32'h2);
		// Hardware-triggered conversions over every count
		for (int n = 0; n < 8; n++) begin
			xfer(1'b1, gat_pkg::GAT_ADDR_CTRL, 32'h0000_000B | (32'(n) << 4));
			clr();
			fire_dly(n[0], 4'(n));
			chk(amp_clk_run, 1'b1);
			while (n_done == 0) @(posedge core_clk);
			fire_dly(1'b0, 4'h0);
			poll(1, 1'b0);
			chk({amp_clk_run, q[2]}, 32'h0);
			chk(t_pre - t_sh, 12 + 18 * n);
			chk(n_gs, n + 1);
			chk({n_trig[3:0], n_pa[3:0], n_pb[3:0], n_fa[3:0]}, {16'h0, 4'h1, 4'(1 - n % 2), 4'(n % 2), 4'h0});
			chk(32'(cyc - t_done >= 48 && cyc - t_done <= 53), 32'h1);
		end
		// Software trigger mode frees the delay-block pre-trigger
		xfer(1'b1, gat_pkg::GAT_ADDR_CTRL, 32'h0000_0111);
		clr();
		@(posedge core_clk);
		chk(input_sel, 32'h0);
		fire_dly(1'b0, 4'h0);
		fire_dly(1'b1, 4'h0);
		chk({n_fa[3:0], n_fb[3:0], n_trig[3:0]}, 32'h110);
		xfer(1'b1, gat_pkg::GAT_ADDR_SWTRIG, 32'h1);
		while (n_done == 0) @(posedge core_clk);
		poll(1, 1'b0);
		chk({n_pb[3:0], n_trig[3:0]}, 32'h11);
		// Disable clears the flag and re-enable restarts startup
		xfer(1'b1, gat_pkg::GAT_ADDR_CTRL, 32'h0);
		xfer(1'b0, gat_pkg::GAT_ADDR_STATUS, 32'h0);
		chk({q[0], analog_on}, 32'h0);
		xfer(1'b1, gat_pkg::GAT_ADDR_CTRL, 32'h1);
		xfer(1'b0, gat_pkg::GAT_ADDR_STATUS, 32'h0);
		chk(q[0], 1'b0);
		chk(input_sel, 32'h2);
		wrap_up();
	end
endmodule

/* tb/gat_dly_model.sv */
// Delay-block partner: issues a pre-trigger and then its hardware trigger.
// Assumes fire is a one-cycle request driven just after a rising core_clk edge.
module gat_dly_model (
	// Clock
	input wire logic core_clk,
	// Request from bench
	input wire logic fire,
	input wire logic sel_b,
	input wire logic [3:0] gap,
	// Triggers toward the sequencer
	output logic dly_trig,
	output logic dly_pretrig_a,
	output logic dly_pretrig_b
);
	timeunit 1ns;
	timeprecision 100ps;
	logic s;

	initial begin
		dly_trig = 1'b0;
		dly_pretrig_a = 1'b0;
		dly_pretrig_b = 1'b0;
	end

	// ==========================================================
	// Pre-trigger one cycle ahead of trigger, after an optional stall
	always begin
		@(posedge core_clk);
		if (fire === 1'b1) begin
			s = sel_b;
			repeat (gap) @(posedge core_clk);
			dly_pretrig_a <= !s;
			dly_pretrig_b <= s;
			@(posedge core_clk);
			dly_pretrig_a <= 1'b0;
			dly_pretrig_b <= 1'b0;
			dly_trig <= 1'b1;
			@(posedge core_clk);
			dly_trig <= 1'b0;
		end
	end
endmodule

/* tb/gat_sequencer_asserts.sv */
// Checker for trigger routing, stage clocks and pass-through.
// Assumes it is bound onto gat_sequencer; one clock domain.
module gat_sequencer_asserts #(
	parameter int AMP_CLK_DIV = 5
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Delay block side
	input wire logic dly_trig,
	input wire logic dly_pretrig_a,
	// ADC side
	input wire logic adc_trig,
	input wire logic adc_pretrig_a,
	input wire logic adc_pretrig_b,
	input wire logic free_pretrig_a,
	// Analog control
	input wire logic analog_on,
	input wire logic sh_clk,
	input wire logic gs_clk,
	input wire logic amp_clk_run,
	input wire logic amp_done
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);

	// ==========================================================
	// Properties
	property p_pre_lead;
		adc_trig |-> $past(adc_pretrig_a) || $past(adc_pretrig_b);
	endproperty
	property p_stage_excl;
		!(sh_clk && gs_clk);
	endproperty
	property p_sh_min;
		$rose(sh_clk) |-> sh_clk [*8];
	endproperty
	property p_final_hold;
		adc_trig && analog_on |-> gs_clk [*8];
	endproperty
	property p_trig_pass;
		!$past(analog_on) && !analog_on |-> adc_trig == $past(dly_trig);
	endproperty
	property p_pre_pass;
		!$past(analog_on) && !analog_on |-> adc_pretrig_a == $past(dly_pretrig_a);
	endproperty
	property p_hw_absorb;
		dly_trig && analog_on && !gs_clk |=> !adc_trig;
	endproperty
	property p_clk_run;
		sh_clk || gs_clk |-> amp_clk_run;
	endproperty
	property p_off_quiet;
		!analog_on |-> !amp_clk_run && !sh_clk && !gs_clk;
	endproperty

	a_pre_lead: assert property (p_pre_lead) else $error("trigger without pre-trigger");
	a_stage_excl: assert property (p_stage_excl) else $error("stage clocks overlap");
	a_sh_min: assert property (p_sh_min) else $error("sample clock high too short");
	a_final_hold: assert property (p_final_hold) else $error("final phase not held");
	a_trig_pass: assert property (p_trig_pass) else $error("trigger not passed");
	a_pre_pass: assert property (p_pre_pass) else $error("pre-trigger not passed");
	a_hw_absorb: assert property (p_hw_absorb) else $error("trigger not absorbed");
	a_clk_run: assert property (p_clk_run) else $error("stage clock with clock stopped");
	a_off_quiet: assert property (p_off_quiet) else $error("activity while off");

	c_conv: cover property (adc_trig && analog_on);
	c_done: cover property (amp_done);
	c_free: cover property (free_pretrig_a);
endmodule

bind gat_sequencer gat_sequencer_asserts #(.AMP_CLK_DIV(AMP_CLK_DIV)) u_chk (
	.core_clk(core_clk),
	.rstn(rstn),
	.dly_trig(dly_trig),
	.dly_pretrig_a(dly_pretrig_a),
	.adc_trig(adc_trig),
	.adc_pretrig_a(adc_pretrig_a),
	.adc_pretrig_b(adc_pretrig_b),
	.free_pretrig_a(free_pretrig_a),
	.analog_on(analog_on),
	.sh_clk(sh_clk),
	.gs_clk(gs_clk),
	.amp_clk_run(amp_clk_run),
	.amp_done(amp_done)
);
